/* File: pmt_cfg.svh */
// constants for the power-management serial target block
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH

// command codes
`define PMT_CMD_CLEAR_FAULTS 8'h03
`define PMT_CMD_STATUS_BYTE  8'h78
`define PMT_CMD_STATUS_WORD  8'h79
`define PMT_CMD_STATUS_VOUT  8'h7A
`define PMT_CMD_STATUS_IOUT  8'h7B
`define PMT_CMD_STATUS_INPUT 8'h7C
`define PMT_CMD_STATUS_TEMP  8'h7D
`define PMT_CMD_STATUS_CML   8'h7E
`define PMT_CMD_STATUS_MFR   8'h80
`define PMT_CMD_READ_VIN     8'h88
`define PMT_CMD_READ_VOUT    8'h8B
`define PMT_CMD_READ_IOUT    8'h8C
`define PMT_CMD_READ_TEMP    8'h8D
`define PMT_CMD_READ_DUTY    8'h94
`define PMT_CMD_READ_FREQ    8'h95
`define PMT_CMD_SNAP_CAPTURE 8'hD7
`define PMT_CMD_SNAP_READ    8'hD8

// addressing
`define PMT_ADDR_PRODUCTION  7'h4B
`define PMT_ADDR_ALERT_RESP  7'h0C
`define PMT_ADDR_DEV_DEFAULT 7'h61
`define PMT_RES_MULT         10'h019
`define PMT_ADDR_LIMIT       10'h080
`define PMT_TRI_BASE         7'h20

// frame lengths in bytes after the address byte
`define PMT_LEN_SEND_BYTE    3'h1
`define PMT_LEN_WRITE_WORD   3'h3
`define PMT_LEN_WORD         5'h02
`define PMT_LEN_BYTE         5'h01
`define PMT_LEN_SNAP         5'h0E
`define PMT_SNAP_COUNT       8'h0D

// status bits
`define PMT_CML_PEC_MASK     8'h20

// timing
`define PMT_CLK_MHZ          25
`define PMT_STRETCH_NS       300
`define PMT_STRETCH_CYC      (((`PMT_STRETCH_NS) * (`PMT_CLK_MHZ) + 999) / 1000)

`endif

/* File: pmt_host_model.sv */
// two-wire bus host model, open-drain, 100 kHz
`timescale 1ns/1ns
module pmt_host_model #(
  parameter int QTR = 39, // quarter bit in link ticks
  parameter int GAP = 781 // bus-free ticks, shortened for run time
) (
  // host tick clock
  input  wire logic clk_link_in,
  // wire levels
  input  wire logic scl_in,
  input  wire logic sda_in,
  // pull-downs, high pulls the wire low
  output logic      scl_low_out,
  output logic      sda_low_out
);
  int timeouts = 0;
  // both lines released at start
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  // wait a number of ticks
  task automatic tk(input int n);
    repeat (n) @(posedge clk_link_in);
  endtask
  // release clock, tolerate stretching under a bound
  task automatic scl_up();
    scl_low_out <= 1'b0;
    tk(1);
    for (int i = 0; i < 400 && scl_in !== 1'b1; i++) tk(1);
    if (scl_in !== 1'b1) timeouts++;
    tk(2 * QTR - 1);
  endtask
  // one bit, data changed only while clock low
  task automatic bit_io(input logic b, output logic s);
    sda_low_out <= ~b;
    tk(QTR);
    scl_up();
    s = sda_in;
    scl_low_out <= 1'b1;
    tk(QTR);
  endtask
  // start or repeated start
  task automatic start();
    sda_low_out <= 1'b0;
    tk(QTR);
    scl_up();
    sda_low_out <= 1'b1;
    tk(2 * QTR);
    scl_low_out <= 1'b1;
    tk(QTR);
  endtask
  // stop, then bus-free time
  task automatic stop();
    sda_low_out <= 1'b1;
    tk(QTR);
    scl_up();
    sda_low_out <= 1'b0;
    tk(GAP);
  endtask
  // write a byte msb first, return acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // read a byte and answer with ack or nack
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, s);
  endtask
endmodule

/* File: pmt_pkg.sv */
// types shared by the power-management serial target block
package pmt_pkg;

  typedef enum logic [1:0] {
    PMT_LVL_LOW,
    PMT_LVL_OPEN,
    PMT_LVL_HIGH
  } pmt_lvl_t;

  typedef enum logic [2:0] {
    PMT_ST_IDLE,
    PMT_ST_RX,
    PMT_ST_RACK,
    PMT_ST_STRETCH,
    PMT_ST_TX,
    PMT_ST_TACK,
    PMT_ST_SKIP
  } pmt_state_t;

endpackage

/* File: pmt_target.sv */
// power-management serial target
//
// What this block does
// - bus clock is 100 kHz only
// - command protocol rev 1.1 over two-wire bus
// - resistor address = 25 * high index + low index
// - strap resistance maps to index 0..24, 10k..100k ladder
// - address 4Bh never answered
// - tri-level straps give 20h..27h; high/high reserved
// - missing high strap reads open in tri-level mode
// - standard transactions with clock stretch
// - no busy flag; host leaves bus-free time after stop
// - check byte sent on reads, checked on writes
// - enabled fault or warning pulls alert low
// - alert low until clear-faults or re-enable
// - bus and alert pins are open-drain only
// - status summaries readable per category
// - live telemetry returned on read commands
// - capture command latches a record
// - a fault stores the record
// - alert response and default addresses unused
// - config writes go to storage
// - address fixed once after reset
`timescale 1ns/1ns
`include "pmt_cfg.svh"

module pmt_target (
  // system clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_in,
  // two-wire bus pins, scl_in also clocks the link capture
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       scl_out,
  output logic                       scl_oe_out,
  output logic                       sda_out,
  output logic                       sda_oe_out,
  // alert line, open drain
  output logic                       fault_alert_line_out,
  output logic                       fault_alert_line_oe_out,
  // address straps from the measurement front end
  input  wire logic                  strap_valid_in,
  input  wire logic                  strap_tri_mode_in,
  input  wire logic                  high_strap_absent_in,
  input  wire logic [9:0]            addr_strap_low_digit_res_in,
  input  wire logic [9:0]            addr_strap_high_digit_res_in,
  input  wire pmt_pkg::pmt_lvl_t     addr_strap_low_digit_lvl_in,
  input  wire pmt_pkg::pmt_lvl_t     addr_strap_high_digit_lvl_in,
  output logic [6:0]                 addr_out,
  output logic                       addr_ok_out,
  // fault events and status from the converter
  input  wire logic [7:0]            fault_event_in,
  input  wire logic [7:0]            fault_enable_in,
  input  wire logic                  out_enable_in,
  input  wire logic [15:0]           status_word_in,
  input  wire logic [7:0]            status_vout_in,
  input  wire logic [7:0]            status_iout_in,
  input  wire logic [7:0]            status_input_in,
  input  wire logic [7:0]            status_temp_in,
  input  wire logic [7:0]            status_cml_in,
  input  wire logic [7:0]            status_mfr_in,
  // live telemetry
  input  wire logic [15:0]           vin_in,
  input  wire logic [15:0]           vout_in,
  input  wire logic [15:0]           iout_in,
  input  wire logic [15:0]           temp_in,
  input  wire logic [15:0]           freq_in,
  input  wire logic [15:0]           duty_in,
  // storage side
  output logic                       nvm_store_out,
  output logic [103:0]               snapshot_out,
  output logic                       cfg_wr_out,
  output logic [7:0]                 cfg_cmd_out,
  output logic [15:0]                cfg_data_out
);
  import pmt_pkg::*;

  localparam logic [9:0] LADDER [25] = '{
    10'h064, 10'h06E, 10'h079, 10'h085, 10'h093, 10'h0A2, 10'h0B2,
    10'h0C4, 10'h0D7, 10'h0ED, 10'h105, 10'h11F, 10'h13C, 10'h15C,
    10'h17F, 10'h1A6, 10'h1D0, 10'h1FF, 10'h232, 10'h26B, 10'h2A9,
    10'h2EE, 10'h339, 10'h38D, 10'h3E8};
  localparam logic [7:0] STRETCH_LAST = 8'(`PMT_STRETCH_CYC - 1);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // nearest ladder step: count midpoints below the reading
  function automatic logic [4:0] res_index(input logic [9:0] r);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 0; i < 24; i++) begin
      if ({r, 1'b0} > ({1'b0, LADDER[i]} + {1'b0, LADDER[i+1]})) begin
        idx = idx + 5'h01;
      end
    end
    return idx;
  endfunction

  // addresses the bus definition keeps for itself
  function automatic logic addr_reserved(input logic [6:0] a);
    return (a <= 7'h08) || (a >= 7'h09 && a <= 7'h0B) ||
           a == `PMT_ADDR_ALERT_RESP || a == 7'h28 ||
           a == 7'h2C || a == 7'h2D || a == 7'h37 ||
           (a >= 7'h40 && a <= 7'h44) || a == `PMT_ADDR_PRODUCTION ||
           a == `PMT_ADDR_DEV_DEFAULT || a >= 7'h78;
  endfunction

  // packet check, polynomial x8+x2+x+1
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] v;
    v = c ^ d;
    for (int i = 0; i < 8; i++) begin
      v = v[7] ? {v[6:0], 1'b0} ^ 8'h07 : {v[6:0], 1'b0};
    end
    return v;
  endfunction

  // ------------------------------------------------------------
  // link domain: bit capture on the bus clock
  // ------------------------------------------------------------
  logic [7:0] link_sh;

  // data is sampled on every rising bus clock edge
  always_ff @(posedge scl_in or posedge rst_in) begin
    if (rst_in) begin
      link_sh <= 8'h00;
    end else begin
      link_sh <= {link_sh[6:0], sda_in};
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers and bus conditions
  // ------------------------------------------------------------
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic scl_rise, scl_fall, start_c, stop_c;

  // two flops per pin, then one history flop for edges
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
    end
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_c  = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_c   = scl_s2 & scl_d & ~sda_d & sda_s2;

  // ------------------------------------------------------------
  // strap address, caught once after reset
  // ------------------------------------------------------------
  logic       addr_done;
  logic [9:0] res_sum;
  pmt_lvl_t   hi_lvl;
  logic [3:0] tri_idx;
  logic [6:0] next_addr;
  logic       next_ok;

  always_comb begin
    res_sum = {5'h00, res_index(addr_strap_high_digit_res_in)} *
              `PMT_RES_MULT +
              {5'h00, res_index(addr_strap_low_digit_res_in)};
    hi_lvl  = high_strap_absent_in ? PMT_LVL_OPEN
                                   : addr_strap_high_digit_lvl_in;
    tri_idx = 4'({2'h0, hi_lvl} * 4'h3) +
              {2'h0, addr_strap_low_digit_lvl_in};
    if (strap_tri_mode_in) begin
      next_addr = `PMT_TRI_BASE + {3'h0, tri_idx};
      next_ok   = !(hi_lvl == PMT_LVL_HIGH &&
                    addr_strap_low_digit_lvl_in == PMT_LVL_HIGH);
    end else begin
      next_addr = res_sum[6:0];
      next_ok   = res_sum < `PMT_ADDR_LIMIT;
    end
  end

  // latch the address at the first valid measurement
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      addr_done   <= 1'b0;
      addr_out    <= 7'h00;
      addr_ok_out <= 1'b0;
    end else if (strap_valid_in && !addr_done) begin
      addr_done   <= 1'b1;
      addr_out    <= next_addr;
      addr_ok_out <= next_ok && !addr_reserved(next_addr);
    end
  end

  // ------------------------------------------------------------
  // transaction engine
  // ------------------------------------------------------------
  pmt_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] crc, tx_sh, st_cnt;
  logic [7:0] wbuf [4];
  logic [2:0] wcount, exp_len;
  logic [4:0] tx_idx, ld_idx, rd_len;
  logic [3:0] sidx;
  logic [15:0] resp_w;
  logic [7:0] resp_b, ld_byte, cml_val;
  logic       addr_ph, in_frame, rd, m_ack, pec_flag, alert;
  logic       clear_req, cap_req, pec_err;
  logic       frame_ok, frame_pec;

  // read answer for the current command
  always_comb begin
    rd_len  = `PMT_LEN_BYTE;
    resp_w  = 16'hFFFF;
    cml_val = status_cml_in | (pec_flag ? `PMT_CML_PEC_MASK : 8'h00);
    ld_idx  = (state == PMT_ST_TACK) ? tx_idx + 5'h01 : 5'h00;
    sidx    = 4'(ld_idx - 5'h01);
    case (wbuf[0])
      `PMT_CMD_STATUS_BYTE:  resp_w = {8'h00, status_word_in[7:0]};
      `PMT_CMD_STATUS_VOUT:  resp_w = {8'h00, status_vout_in};
      `PMT_CMD_STATUS_IOUT:  resp_w = {8'h00, status_iout_in};
      `PMT_CMD_STATUS_INPUT: resp_w = {8'h00, status_input_in};
      `PMT_CMD_STATUS_TEMP:  resp_w = {8'h00, status_temp_in};
      `PMT_CMD_STATUS_CML:   resp_w = {8'h00, cml_val};
      `PMT_CMD_STATUS_MFR:   resp_w = {8'h00, status_mfr_in};
      `PMT_CMD_STATUS_WORD: begin
        resp_w = status_word_in;
        rd_len = `PMT_LEN_WORD;
      end
      `PMT_CMD_READ_VIN:  begin resp_w = vin_in;  rd_len = `PMT_LEN_WORD; end
      `PMT_CMD_READ_VOUT: begin resp_w = vout_in; rd_len = `PMT_LEN_WORD; end
      `PMT_CMD_READ_IOUT: begin resp_w = iout_in; rd_len = `PMT_LEN_WORD; end
      `PMT_CMD_READ_TEMP: begin resp_w = temp_in; rd_len = `PMT_LEN_WORD; end
      `PMT_CMD_READ_FREQ: begin resp_w = freq_in; rd_len = `PMT_LEN_WORD; end
      `PMT_CMD_READ_DUTY: begin resp_w = duty_in; rd_len = `PMT_LEN_WORD; end
      `PMT_CMD_SNAP_READ: rd_len = `PMT_LEN_SNAP;
      default: resp_w = 16'hFFFF;
    endcase
    if (wbuf[0] == `PMT_CMD_SNAP_READ) begin
      resp_b = (ld_idx == 5'h00) ? `PMT_SNAP_COUNT
                                 : snapshot_out[{sidx, 3'h0} +: 8];
    end else begin
      resp_b = ld_idx[0] ? resp_w[15:8] : resp_w[7:0];
    end
    ld_byte = (ld_idx == rd_len) ? crc : resp_b;
  end

  // write frame checks at stop
  always_comb begin
    exp_len   = (wbuf[0] == `PMT_CMD_CLEAR_FAULTS ||
                 wbuf[0] == `PMT_CMD_SNAP_CAPTURE) ? `PMT_LEN_SEND_BYTE
                                                   : `PMT_LEN_WRITE_WORD;
    frame_pec = wcount == exp_len + 3'h1;
    frame_ok  = (wcount == exp_len) || (frame_pec && crc == 8'h00);
  end

  // bus state machine with acknowledge, stretch and transmit
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state      <= PMT_ST_IDLE;
      bit_cnt    <= 4'h0;
      crc        <= 8'h00;
      tx_sh      <= 8'h00;
      st_cnt     <= 8'h00;
      wbuf       <= '{default: 8'h00};
      wcount     <= 3'h0;
      tx_idx     <= 5'h00;
      addr_ph    <= 1'b0;
      in_frame   <= 1'b0;
      rd         <= 1'b0;
      m_ack      <= 1'b0;
      sda_oe_out <= 1'b0;
      scl_oe_out <= 1'b0;
      clear_req  <= 1'b0;
      cap_req    <= 1'b0;
      pec_err    <= 1'b0;
      cfg_wr_out <= 1'b0;
      cfg_cmd_out  <= 8'h00;
      cfg_data_out <= 16'h0000;
    end else begin
      clear_req  <= 1'b0;
      cap_req    <= 1'b0;
      pec_err    <= 1'b0;
      cfg_wr_out <= 1'b0;
      if (start_c) begin
        state    <= PMT_ST_RX;
        bit_cnt  <= 4'h0;
        addr_ph  <= 1'b1;
        in_frame <= 1'b1;
        if (!in_frame) begin
          crc    <= 8'h00;
          wcount <= 3'h0;
        end
      end else if (stop_c) begin
        state      <= PMT_ST_IDLE;
        in_frame   <= 1'b0;
        sda_oe_out <= 1'b0;
        scl_oe_out <= 1'b0;
        if (!rd && wcount != 3'h0) begin
          pec_err <= frame_pec && crc != 8'h00;
          if (frame_ok) begin
            clear_req  <= wbuf[0] == `PMT_CMD_CLEAR_FAULTS;
            cap_req    <= wbuf[0] == `PMT_CMD_SNAP_CAPTURE;
            cfg_wr_out <= exp_len == `PMT_LEN_WRITE_WORD;
            cfg_cmd_out  <= wbuf[0];
            cfg_data_out <= {wbuf[2], wbuf[1]};
          end
        end
      end else begin
        unique case (state)
          PMT_ST_IDLE, PMT_ST_SKIP: begin
            sda_oe_out <= 1'b0;
          end
          PMT_ST_RX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              crc     <= crc8(crc, link_sh);
              bit_cnt <= 4'h0;
              addr_ph <= 1'b0;
              if (!addr_ph) begin
                if (wcount < 3'h4) begin
                  wbuf[wcount[1:0]] <= link_sh;
                end
                wcount     <= (wcount == 3'h7) ? wcount : wcount + 3'h1;
                sda_oe_out <= 1'b1;
                state      <= PMT_ST_RACK;
              end else if (addr_ok_out && link_sh[7:1] == addr_out) begin
                rd         <= link_sh[0];
                sda_oe_out <= 1'b1;
                state      <= PMT_ST_RACK;
              end else begin
                state <= PMT_ST_SKIP;
              end
            end
          end
          PMT_ST_RACK: begin
            if (scl_fall) begin
              sda_oe_out <= 1'b0;
              if (rd) begin
                scl_oe_out <= 1'b1;
                st_cnt     <= 8'h00;
                state      <= PMT_ST_STRETCH;
              end else begin
                state <= PMT_ST_RX;
              end
            end
          end
          PMT_ST_STRETCH: begin
            st_cnt <= st_cnt + 8'h01;
            if (st_cnt == STRETCH_LAST) begin
              tx_idx     <= ld_idx;
              tx_sh      <= ld_byte;
              crc        <= crc8(crc, ld_byte);
              sda_oe_out <= ~ld_byte[7];
              scl_oe_out <= 1'b0;
              bit_cnt    <= 4'h0;
              state      <= PMT_ST_TX;
            end
          end
          PMT_ST_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                sda_oe_out <= 1'b0;
                state      <= PMT_ST_TACK;
              end else begin
                tx_sh      <= {tx_sh[6:0], 1'b0};
                sda_oe_out <= ~tx_sh[6];
              end
            end
          end
          PMT_ST_TACK: begin
            if (scl_rise) begin
              m_ack <= ~sda_s2;
            end else if (scl_fall) begin
              if (m_ack && tx_idx < rd_len) begin
                tx_idx     <= ld_idx;
                tx_sh      <= ld_byte;
                crc        <= crc8(crc, ld_byte);
                sda_oe_out <= ~ld_byte[7];
                bit_cnt    <= 4'h0;
                state      <= PMT_ST_TX;
              end else begin
                state <= PMT_ST_SKIP;
              end
            end
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // alert, communication flag and snapshot record
  // ------------------------------------------------------------
  logic fault_ev, oen_d, reenable;

  assign fault_ev = |(fault_event_in & fault_enable_in);
  assign reenable = out_enable_in & ~oen_d;

  // sticky alert and check flag; set beats clear
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      alert    <= 1'b0;
      pec_flag <= 1'b0;
      oen_d    <= 1'b0;
    end else begin
      oen_d <= out_enable_in;
      if (fault_ev || pec_err) begin
        alert <= 1'b1;
      end else if (clear_req || reenable) begin
        alert <= 1'b0;
      end
      if (pec_err) begin
        pec_flag <= 1'b1;
      end else if (clear_req) begin
        pec_flag <= 1'b0;
      end
    end
  end

  // record on command or fault
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      snapshot_out  <= '0;
      nvm_store_out <= 1'b0;
    end else begin
      nvm_store_out <= fault_ev;
      if (cap_req || fault_ev) begin
        snapshot_out <= {status_word_in[7:0], duty_in, freq_in, temp_in,
                         iout_in, vout_in, vin_in};
      end
    end
  end

  // open-drain pins only ever pull low
  assign scl_out                 = 1'b0;
  assign sda_out                 = 1'b0;
  assign fault_alert_line_out    = 1'b0;
  assign fault_alert_line_oe_out = alert;

endmodule

/* File: pmt_target_assertions.sv */
// checks on the serial target ports
`timescale 1ns/1ns
module pmt_target_assertions (
  // clock and reset
  input wire logic         clk_sys_in,
  input wire logic         rst_in,
  // bus pins and alert
  input wire logic         scl_in,
  input wire logic         scl_out,
  input wire logic         scl_oe_out,
  input wire logic         sda_out,
  input wire logic         sda_oe_out,
  input wire logic         fault_alert_line_out,
  input wire logic         fault_alert_line_oe_out,
  // events, records and address
  input wire logic [7:0]   fault_event_in,
  input wire logic [7:0]   fault_enable_in,
  input wire logic         out_enable_in,
  input wire logic [15:0]  vin_in,
  input wire logic         nvm_store_out,
  input wire logic [103:0] snapshot_out,
  input wire logic         cfg_wr_out,
  input wire logic [6:0]   addr_out,
  input wire logic         addr_ok_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // an enabled fault seen this cycle
  wire logic ev = |(fault_event_in & fault_enable_in);
  chk_pins_open_drain: assert property (
    !scl_out && !sda_out && !fault_alert_line_out)
    else $error("pin driven high");
  chk_stretch_len: assert property (
    $rose(scl_oe_out) |-> scl_oe_out[*8] ##1 !scl_oe_out)
    else $error("bad stretch");
  chk_data_on_low: assert property (
    $rose(sda_oe_out) |-> !scl_in)
    else $error("sda on high scl");
  chk_alert_raise: assert property (
    ev |=> fault_alert_line_oe_out)
    else $error("alert not raised");
  chk_alert_reenable: assert property (
    $rose(out_enable_in) && !ev ##1 !ev |-> ##[0:1] !fault_alert_line_oe_out)
    else $error("alert kept on re-enable");
  chk_store_pulse: assert property (
    ev |=> nvm_store_out)
    else $error("no store on fault");
  chk_snap_vin: assert property (
    ev |=> snapshot_out[15:0] == $past(vin_in))
    else $error("snapshot vin wrong");
  chk_cfg_pulse: assert property (
    cfg_wr_out |=> !cfg_wr_out)
    else $error("long config pulse");
  chk_addr_fixed: assert property (
    addr_ok_out |=> $stable(addr_out) && addr_ok_out)
    else $error("address moved");
  chk_addr_reserved: assert property (
    addr_ok_out |-> addr_out != 7'h4B && addr_out != 7'h0C
      && addr_out != 7'h61)
    else $error("reserved address");
endmodule

bind pmt_target pmt_target_assertions u_chk (.*);

/* File: test_pmbus_target_addr_alert.sv */
// self-checking bench for the serial target
`timescale 1ns/1ns
`include "pmt_cfg.svh"
module test_pmbus_target_addr_alert;
  import pmt_pkg::*;
  logic         clk_sys_in = 1'b0;
  logic         clk_link = 1'b0;
  logic         rst_in = 1'b1;
  logic         scl_oe, sda_oe, h_scl, h_sda, cfg_wr, nvm_st, al_oe, ok;
  logic         tri_m = 1'b0, valid = 1'b0, absent = 1'b0, oen = 1'b0;
  logic [9:0]   r_lo = 10'h000, r_hi = 10'h000;
  pmt_lvl_t     l_lo = PMT_LVL_LOW, l_hi = PMT_LVL_LOW;
  logic [7:0]   ev = 8'h00, en = 8'hFF, cfg_c, st [6];
  logic [15:0]  cfg_d, tel [7];
  logic [6:0]   addr;
  logic [103:0] snap;
  logic [23:0]  wc = 24'h000000;
  int           errors = 0, n_tests = 0, wr_n = 0, st_n = 0;
  localparam logic [7:0] ADW = 8'h4C;
  // wire levels with pull-ups
  wire scl = ~(h_scl | scl_oe);
  wire sda = ~(h_sda | sda_oe);
  // clocks
  always #20 clk_sys_in = ~clk_sys_in;
  always #32 clk_link = ~clk_link;
  // telemetry and status values
  initial begin
    for (int i = 0; i < 7; i++) tel[i] = 16'h1357 * (i + 1);
    for (int i = 0; i < 6; i++) st[i] = 8'h11 * (i + 1);
  end
  pmt_target dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl),
    .sda_in(sda), .scl_out(), .scl_oe_out(scl_oe), .sda_out(),
    .sda_oe_out(sda_oe), .fault_alert_line_out(),
    .fault_alert_line_oe_out(al_oe), .strap_valid_in(valid),
    .strap_tri_mode_in(tri_m), .high_strap_absent_in(absent),
    .addr_strap_low_digit_res_in(r_lo), .addr_strap_high_digit_res_in(r_hi),
    .addr_strap_low_digit_lvl_in(l_lo), .addr_strap_high_digit_lvl_in(l_hi),
    .addr_out(addr), .addr_ok_out(ok), .fault_event_in(ev),
    .fault_enable_in(en), .out_enable_in(oen), .status_word_in(tel[6]),
    .status_vout_in(st[0]), .status_iout_in(st[1]), .status_input_in(st[2]),
    .status_temp_in(st[3]), .status_cml_in(st[4]), .status_mfr_in(st[5]),
    .vin_in(tel[0]), .vout_in(tel[1]), .iout_in(tel[2]), .temp_in(tel[3]),
    .freq_in(tel[4]), .duty_in(tel[5]), .nvm_store_out(nvm_st),
    .snapshot_out(snap), .cfg_wr_out(cfg_wr), .cfg_cmd_out(cfg_c),
    .cfg_data_out(cfg_d));
  pmt_host_model host (.clk_link_in(clk_link), .scl_in(scl), .sda_in(sda),
    .scl_low_out(h_scl), .sda_low_out(h_sda));
  // count pulses
  always @(posedge clk_sys_in) begin
    if (cfg_wr === 1'b1) wr_n <= wr_n + 1;
    if (cfg_wr === 1'b1) wc <= {cfg_c, cfg_d};
    if (nvm_st === 1'b1) st_n <= st_n + 1;
  end
  // compare and report
  task automatic chk(input logic [103:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // packet check byte
  function automatic logic [7:0] crc8(input logic [7:0] c, d);
    c = c ^ d;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction
  // latch straps, then disturb them
  task automatic strap(input logic t, input logic [9:0] lo, hi,
    input pmt_lvl_t ll, lh, input logic ab, input logic [6:0] ea,
    input logic eok);
    rst_in = 1'b1;
    valid = 1'b0;
    tri_m = t;
    r_lo = lo;
    r_hi = hi;
    l_lo = ll;
    l_hi = lh;
    absent = ab;
    repeat (2) @(negedge clk_sys_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    valid = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    r_lo = r_lo ^ 10'h0FF;
    l_lo = PMT_LVL_HIGH;
    repeat (6) @(negedge clk_sys_in);
    chk(ok, eok);
    if (eok) chk(addr, ea);
  endtask
  // write frame, optional check byte
  task automatic send(input logic [7:0] q[$], input int pec, input logic ea);
    logic a;
    logic [7:0] c;
    c = 8'h00;
    host.start();
    foreach (q[i]) begin
      host.wr_byte(q[i], a);
      chk(a, ea);
      c = crc8(c, q[i]);
    end
    if (pec > 0) host.wr_byte(c ^ ((pec == 2) ? 8'h01 : 8'h00), a);
    host.stop();
  endtask
  // read frame with check byte
  task automatic rd(input logic [7:0] cmd, input int n,
    input logic [15:0] exp, mask);
    logic a;
    logic [7:0] b, c;
    logic [15:0] v;
    v = 16'h0000;
    c = crc8(crc8(crc8(8'h00, ADW), cmd), ADW | 8'h01);
    host.start();
    host.wr_byte(ADW, a);
    host.wr_byte(cmd, a);
    host.start();
    host.wr_byte(ADW | 8'h01, a);
    chk(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      host.rd_byte(1'b1, b);
      c = crc8(c, b);
      v[8*i +: 8] = b;
    end
    host.rd_byte(1'b0, b);
    host.stop();
    chk(b, c);
    chk(v & mask, exp);
  endtask
  // faults, alert, snapshot and clear
  task automatic fault_case();
    en = 8'hFE;
    ev = 8'h01;
    @(negedge clk_sys_in);
    ev = 8'h02;
    @(negedge clk_sys_in);
    ev = 8'h00;
    chk(al_oe, 1'b1);
    chk(snap[95:0], {tel[5], tel[4], tel[3], tel[2], tel[1], tel[0]});
    @(negedge clk_sys_in);
    chk(st_n, 1);
    send('{ADW, `PMT_CMD_CLEAR_FAULTS}, 0, 1'b1);
    chk(al_oe, 1'b0);
    tel[0] = 16'hBEEF;
    send('{ADW, `PMT_CMD_SNAP_CAPTURE}, 0, 1'b1);
    chk(snap[15:0], 16'hBEEF);
  endtask
  // verdict
  task automatic complete_run();
    errors += host.timeouts;
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #3600000;
    errors++;
    complete_run();
  end
  // main sequence
  initial begin
    strap(0, 10'h064, 10'h085, PMT_LVL_LOW, PMT_LVL_LOW, 0, 7'h4B, 0);
    strap(0, 10'h13C, 10'h064, PMT_LVL_LOW, PMT_LVL_LOW, 0, 7'h0C, 0);
    strap(0, 10'h339, 10'h085, PMT_LVL_LOW, PMT_LVL_LOW, 0, 7'h61, 0);
    strap(1, 10'h000, 10'h000, PMT_LVL_OPEN, PMT_LVL_HIGH, 1, 7'h24, 1);
    strap(1, 10'h000, 10'h000, PMT_LVL_HIGH, PMT_LVL_HIGH, 0, 7'h00, 0);
    strap(1, 10'h000, 10'h000, PMT_LVL_HIGH, PMT_LVL_LOW, 0, 7'h22, 1);
    strap(0, 10'h15C, 10'h06E, PMT_LVL_LOW, PMT_LVL_LOW, 0, 7'h26, 1);
    send('{ADW + 8'h02}, 0, 1'b0);
    send('{ADW, 8'h21, 8'h34, 8'h12}, 1, 1'b1);
    chk(wr_n, 1);
    chk(wc, 24'h211234);
    send('{ADW, 8'h21, 8'h78, 8'h56}, 2, 1'b1);
    chk(wr_n, 1);
    chk(al_oe, 1'b1);
    rd(`PMT_CMD_STATUS_CML, 1, 16'h0020, 16'h0020);
    rd(`PMT_CMD_READ_VIN, 2, tel[0], 16'hFFFF);
    @(negedge clk_sys_in);
    oen = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    chk(al_oe, 1'b0);
    fault_case();
    complete_run();
  end
endmodule
